// >>> dv/ust_ee_model.sv
// Purpose: memory model answering the block's EEPROM requests
// Assumes: requests hold until acknowledged
// Notes: read data is inverted once released
`timescale 1ns/1ps

module ust_ee_model
    import ust_pkg::*;
#(
    parameter int DELAY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request side
    input wire ust_ee_req_type ee_req,
    output logic ee_ack,
    output logic [7:0] ee_rdata
);
    logic [7:0] mem [256];
    int cnt;

    initial begin
        ee_ack = 1'b0;
        ee_rdata = 8'h5A;
        cnt = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer after a fixed wait
    always @(negedge clk) begin
        if (ee_ack) begin
            ee_ack <= 1'b0;
            ee_rdata <= ~ee_rdata;
        end else if (reset || !ee_req.valid) begin
            cnt <= 0;
        end else if (cnt < DELAY) begin
            cnt <= cnt + 1;
        end else begin
            ee_ack <= 1'b1;
            cnt <= 0;
            if (ee_req.write) begin
                mem[ee_req.addr] <= ee_req.data;
            end else begin
                ee_rdata <= mem[ee_req.addr];
            end
        end
    end
endmodule

// >>> dv/ust_port_tuning_tb.sv
// Purpose: self-checking bench of the serial port tuning and status block
// Assumes: inputs change at the falling edge
// Notes: EEPROM side answered by a slow memory model
`timescale 1ns/1ps

module ust_port_tuning_tb
    import ust_pkg::*;
;
    logic mclk, reset, setup_valid, ctl_done, ctl_stall, ee_ack, status_poll, st_valid, st_ready;
    logic [7:0] ctl_rdata, ee_rdata, device_config_one, rd;
    logic stl, ce;
    ust_setup_type setup;
    ust_ee_req_type ee_req;
    ust_st_word_type st_word;
    logic [1:0] os_tick, tx_char_done, tx_hold, rx_bit_start, rx_sample, bin_req, bin_send;
    logic [1:0] bin_zlp;
    logic [1:0][7:0] bin_count, bout_count, irq_ident;
    logic [1:0][8:0] bin_len;
    int bad_count, n_tests;
    logic [7:0] ri [10] = '{IDX_GAP1, IDX_GAP2, IDX_SAMP, IDX_EPC1, IDX_EPC2, IDX_ZEN, IDX_SZL1,
        IDX_SZH1, IDX_SZL2, IDX_SZH2};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h77, 8'h14, 8'h14, 8'h0F, 8'h0F, 8'h80, 8'h0F, 8'h80};
    logic [7:0] st_exp [13] = '{8'hA1, 8'h00, 8'hB2, 8'h00, 8'h03, 8'h07, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h05, 8'h00, 8'h00};

    ust_port_tuning i_ust_port_tuning (.mclk(mclk), .reset(reset), .ce(ce),
        .setup_valid(setup_valid), .setup(setup), .ctl_done(ctl_done), .ctl_stall(ctl_stall),
        .ctl_rdata(ctl_rdata), .ee_req(ee_req), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
        .os_tick(os_tick), .tx_char_done(tx_char_done), .tx_hold(tx_hold),
        .rx_bit_start(rx_bit_start), .rx_sample(rx_sample), .bin_req(bin_req),
        .bin_count(bin_count), .bout_count(bout_count), .bin_send(bin_send), .bin_zlp(bin_zlp),
        .bin_len(bin_len), .irq_ident(irq_ident), .device_config_one(device_config_one),
        .status_poll(status_poll), .st_valid(st_valid), .st_ready(st_ready), .st_word(st_word));

    ust_ee_model #(.DELAY(5)) i_ust_ee_model (.clk(mclk), .reset(reset), .ee_req(ee_req),
        .ee_ack(ee_ack), .ee_rdata(ee_rdata));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic close_out;
        $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic fail(input string nm);
        bad_count++;
        $display("[ERR] %s expected answer seen timeout", nm);
        close_out();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Access tasks
    task automatic ctl(input logic [7:0] bm, rq, input logic [15:0] wv, wi, wl);
        int k;
        @(negedge mclk);
        setup = '{bm, rq, wv, wi, wl};
        setup_valid = 1'b1;
        for (k = 0; k < 60; k++) begin
            @(negedge mclk);
            setup_valid = 1'b0;
            if (ctl_done === 1'b1 || ctl_stall === 1'b1) break;
        end
        if (k == 60) fail("ctl");
        rd = ctl_rdata;
        stl = ctl_stall;
    endtask

    task automatic wr(input logic [7:0] idx, d);
        ctl(8'h40, 8'h0E, {8'h00, d}, {8'h00, idx}, 16'h0000);
    endtask

    task automatic rdr(input logic [7:0] idx);
        ctl(8'hC0, 8'h0D, 16'h0000, {8'h00, idx}, 16'h0001);
    endtask

    task automatic binq(input int p, input logic s, z, input logic [8:0] len);
        @(negedge mclk);
        bin_req[p] = 1'b1;
        @(negedge mclk);
        bin_req[p] = 1'b0;
        chk("bin_send", bin_send[p], s);
        chk("bin_zlp", bin_zlp[p], z);
        if (s) chk("bin_len", bin_len[p], len);
    endtask

    task automatic poll(input int n);
        int k;
        int got;
        got = 0;
        for (k = 0; k < 80 && got < n; k++) begin
            @(negedge mclk);
            status_poll = (k == 0 || k == 4);
            st_ready = k[0];
            if (st_valid === 1'b1 && st_ready) begin
                chk("st_data", st_word.data, st_exp[got]);
                chk("st_last", st_word.last, got == n - 1);
                got++;
            end
        end
        status_poll = 1'b0;
        if (got < n) fail("status");
        repeat (4) @(negedge mclk);
        chk("st_idle", st_valid, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        int p;
        {setup_valid, status_poll, st_ready, os_tick, tx_char_done, rx_bit_start, bin_req} = '0;
        {setup, device_config_one, bin_count, bout_count, irq_ident} = '0;
        {bad_count, n_tests} = '0;
        ce = 1'b1;
        reset = 1'b1;
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        for (n = 0; n < 10; n++) begin
            rdr(ri[n]);
            chk("reg_reset", rd, rv[n]);
        end
        wr(IDX_GAP2, 8'hC3);
        rdr(IDX_GAP2);
        chk("gap2", rd, 8'hC3);
        wr(IDX_SZH1, 8'hFF);
        rdr(IDX_SZH1);
        chk("size_high", rd, 8'h81);
        wr(8'h50, 8'h66);
        rdr(8'h50);
        chk("unmapped", rd, 8'h00);
        ctl(8'h40, 8'h0E, 16'h09A5, 16'h0010, 16'h0000);
        chk("ee_wr_stall", stl, 1'b0);
        ctl(8'hC0, 8'h0D, 16'h0900, 16'h0010, 16'h0001);
        chk("ee_rd", rd, 8'hA5);
        ctl(8'h40, 8'h0E, 16'h09A5, 16'h0010, 16'h0001);
        chk("ee_bad_len", stl, 1'b1);
        ctl(8'hC0, 8'h0E, 16'h0900, 16'h0010, 16'h0001);
        chk("ee_bad_req", stl, 1'b1);
        wr(IDX_SAMP, 8'h37);
        for (p = 0; p < 2; p++) begin
            @(negedge mclk);
            rx_bit_start[p] = 1'b1;
            @(negedge mclk);
            rx_bit_start[p] = 1'b0;
            os_tick[p] = 1'b1;
            for (n = 1; n <= 20; n++) begin
                @(negedge mclk);
                if (rx_sample[p] === 1'b1) break;
            end
            os_tick[p] = 1'b0;
            if (n > 20) fail("sample");
            chk("sample_tick", n[15:0], (p == 0) ? 16'd8 : 16'd4);
        end
        wr(IDX_GAP1, 8'h03);
        wr(IDX_GAP2, 8'h00);
        @(negedge mclk);
        tx_char_done = 2'b11;
        @(negedge mclk);
        tx_char_done = 2'b00;
        chk("hold_one", tx_hold[0], 1'b1);
        chk("hold_two", tx_hold[1], 1'b0);
        os_tick[0] = 1'b1;
        for (n = 1; n <= 60; n++) begin
            @(negedge mclk);
            if (tx_hold[0] !== 1'b1) break;
        end
        os_tick[0] = 1'b0;
        if (n > 60) fail("gap");
        chk("gap_ticks", n >= 32 && n <= 48, 1'b1);
        wr(IDX_EPC1, 8'h03);
        binq(0, 1'b0, 1'b0, 9'd0);
        binq(0, 1'b0, 1'b0, 9'd0);
        binq(0, 1'b0, 1'b1, 9'd0);
        wr(IDX_ZEN, 8'h0E);
        for (n = 0; n < 4; n++) binq(0, 1'b0, 1'b0, 9'd0);
        bin_count = {8'h20, 8'hC8};
        ce = 1'b0;
        binq(1, 1'b0, 1'b0, 9'd0);
        ce = 1'b1;
        wr(IDX_SZL1, 8'h05);
        wr(IDX_SZH1, 8'h81);
        binq(0, 1'b1, 1'b0, 9'd200);
        wr(IDX_SZH1, 8'h80);
        binq(0, 1'b1, 1'b0, 9'd5);
        wr(IDX_SZH1, 8'h00);
        binq(0, 1'b1, 1'b0, 9'd200);
        binq(1, 1'b1, 1'b0, 9'd15);
        irq_ident = {8'hB2, 8'hA1};
        bin_count = {8'h00, 8'h07};
        bout_count = {8'h05, 8'h00};
        poll(5);
        device_config_one = 8'h40;
        poll(13);
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
        rdr(IDX_GAP1);
        chk("gap1_reset", rd, 8'h00);
        close_out();
    end
endmodule

// >>> rtl/ust_pkg.sv
// Purpose: constants and types of the serial port tuning and status block
// Assumes: register indices are the byte indices used by vendor requests
// Notes: ports are numbered 0 (port one) and 1 (port two)
package ust_pkg;

////////////////////////////////////////////////////////////////////////////////
// Register indices
localparam logic [7:0] IDX_GAP1 = 8'h2C;
localparam logic [7:0] IDX_GAP2 = 8'h2E;
localparam logic [7:0] IDX_SAMP = 8'h30;
localparam logic [7:0] IDX_EPC1 = 8'h3A;
localparam logic [7:0] IDX_EPC2 = 8'h3C;
localparam logic [7:0] IDX_ZEN = 8'h3E;
localparam logic [7:0] IDX_SZL1 = 8'h3F;
localparam logic [7:0] IDX_SZH1 = 8'h40;
localparam logic [7:0] IDX_SZL2 = 8'h43;
localparam logic [7:0] IDX_SZH2 = 8'h44;

////////////////////////////////////////////////////////////////////////////////
// Reset values and field positions
localparam logic [7:0] RST_GAP = 8'h00;
localparam logic [7:0] RST_SAMP = 8'h77;
localparam logic [7:0] RST_EPC = 8'h14;
localparam logic [7:0] RST_ZEN = 8'h0F;
localparam logic [7:0] RST_SZL = 8'h0F;
localparam logic [7:0] RST_SZH = 8'h80;
localparam logic [7:0] SZH_MASK = 8'h81;
localparam int SZH_EN_BIT = 7;
localparam int SZH_MSB_BIT = 0;
localparam int ZEN_STEP = 2;
localparam int SAMP_W = 4;
localparam int CFG_EXT_BIT = 6;

////////////////////////////////////////////////////////////////////////////////
// Vendor request codes
localparam logic [7:0] RT_VOUT = 8'h40;
localparam logic [7:0] RT_VIN = 8'hC0;
localparam logic [7:0] REQ_WR = 8'h0E;
localparam logic [7:0] REQ_RD = 8'h0D;
localparam logic [7:0] APP_REG = 8'h00;
localparam logic [7:0] APP_EE = 8'h09;
localparam logic [15:0] LEN_WR = 16'h0000;
localparam logic [15:0] LEN_RD = 16'h0001;

////////////////////////////////////////////////////////////////////////////////
// Timing and sizes
localparam logic [3:0] OS_LAST = 4'hF;
localparam logic [3:0] ST_LAST_BASE = 4'h4;
localparam logic [3:0] ST_LAST_EXT = 4'hC;
localparam logic [9:0] PKT_MAX = 10'h200;
localparam int ST_FIFO_DEPTH = 4;

////////////////////////////////////////////////////////////////////////////////
// Types
typedef struct packed {
    logic [7:0] bm_request_type;
    logic [7:0] b_request;
    logic [15:0] w_value;
    logic [15:0] w_index;
    logic [15:0] w_length;
} ust_setup_type;

typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
} ust_ee_req_type;

typedef struct packed {
    logic last;
    logic [7:0] data;
} ust_st_word_type;

typedef enum logic [0:0] {CS_IDLE, CS_EE} ust_ctl_state_type;

endpackage

// >>> rtl/ust_port_tuning.sv
// Purpose: per-port gap, sample point, bulk-in policy, vendor and status logic
// Assumes: all inputs synchronous to mclk; os_tick is the 16x baud tick
// Notes: status bytes pass through a 4-word FIFO to the interrupt endpoint
//
// What this block does
// R1 - Transmitter idles gap register value times baud period between characters
// R2 - Separate writable gap register per port at indices 44 and 46
// R3 - Each port divides a sixteen-times oversampling tick for its baud timing
// R4 - Receiver samples at oversampling tick given by 4-bit value, 7 is mid-bit
// R5 - Sample register index 48: port one bits 3:0, port two bits 7:4
// R6 - Zero-length packet only when no data and bulk-in FIFO empty
// R7 - Count empty bulk-in requests; zero-length packet when count reaches setting
// R8 - Enable bits 0 and 2 of index 62 gate zero-length packets
// R9 - Packet size is nine-bit threshold, low byte 63/67, top bit 64/68
// R10 - Threshold only used while bit 7 of the high register is set
// R11 - EEPROM write: 0x40, 0x0E, wValue 0x09 and data, wIndex location
// R12 - EEPROM read: 0xC0, 0x0D, wValue 0x0900, one byte returned
// R13 - Status poll returns five bytes: ident, reserved, ident, reserved, FIFO status
// R14 - Config bit 6 appends eight FIFO count bytes to the status report
// R15 - Appended bytes: counts at 6,7 and 10,11, reserved 8,9,12,13
// R16 - FIFO status bits: out-empty and in-has-data, port one 0-1, two 4-5
// R17 - Reserved report bytes and reserved register bits read as zero
// R18 - Gap value zero adds no idle time after the stop bit
`timescale 1ns/1ps

module ust_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ust_port_tuning
    import ust_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // Vendor control requests
    input wire logic setup_valid,
    input wire ust_setup_type setup,
    output logic ctl_done,
    output logic ctl_stall,
    output logic [7:0] ctl_rdata,
    // EEPROM access
    output ust_ee_req_type ee_req,
    input wire logic ee_ack,
    input wire logic [7:0] ee_rdata,
    // UART timing
    input wire logic [1:0] os_tick,
    input wire logic [1:0] tx_char_done,
    output logic [1:0] tx_hold,
    input wire logic [1:0] rx_bit_start,
    output logic [1:0] rx_sample,
    // Bulk-in policy
    input wire logic [1:0] bin_req,
    input wire logic [1:0][7:0] bin_count,
    input wire logic [1:0][7:0] bout_count,
    output logic [1:0] bin_send,
    output logic [1:0] bin_zlp,
    output logic [1:0][8:0] bin_len,
    // Status endpoint
    input wire logic [1:0][7:0] irq_ident,
    input wire logic [7:0] device_config_one,
    input wire logic status_poll,
    output logic st_valid,
    input wire logic st_ready,
    output ust_st_word_type st_word
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0][7:0] gap_r;
    logic [7:0] samp_r;
    logic [1:0][7:0] epc_r;
    logic [7:0] zen_r;
    logic [1:0][7:0] szl_r;
    logic [1:0][7:0] szh_r;
    ust_ctl_state_type ctl_state_r;
    logic is_wr;
    logic is_rd;
    logic [7:0] app;
    logic [7:0] idx;
    logic reg_wr;
    logic [7:0] rd_mux;

    assign is_wr = setup.bm_request_type == RT_VOUT && setup.b_request == REQ_WR
        && setup.w_length == LEN_WR; // R11
    assign is_rd = setup.bm_request_type == RT_VIN && setup.b_request == REQ_RD
        && setup.w_length == LEN_RD; // R12
    assign app = setup.w_value[15:8];
    assign idx = setup.w_index[7:0];
    assign reg_wr = ce && setup_valid && ctl_state_r == CS_IDLE && is_wr && app == APP_REG;

    always_ff @(posedge mclk) begin
        if (reset) begin
            gap_r <= {RST_GAP, RST_GAP};
            samp_r <= RST_SAMP;
            epc_r <= {RST_EPC, RST_EPC};
            zen_r <= RST_ZEN;
            szl_r <= {RST_SZL, RST_SZL};
            szh_r <= {RST_SZH, RST_SZH};
        end else if (reg_wr) begin
            case (idx)
                IDX_GAP1: gap_r[0] <= setup.w_value[7:0]; // R2
                IDX_GAP2: gap_r[1] <= setup.w_value[7:0]; // R2
                IDX_SAMP: samp_r <= setup.w_value[7:0]; // R5
                IDX_EPC1: epc_r[0] <= setup.w_value[7:0]; // R7
                IDX_EPC2: epc_r[1] <= setup.w_value[7:0]; // R7
                IDX_ZEN: zen_r <= setup.w_value[7:0]; // R8
                IDX_SZL1: szl_r[0] <= setup.w_value[7:0]; // R9
                IDX_SZL2: szl_r[1] <= setup.w_value[7:0]; // R9
                IDX_SZH1: szh_r[0] <= setup.w_value[7:0] & SZH_MASK; // R17
                IDX_SZH2: szh_r[1] <= setup.w_value[7:0] & SZH_MASK; // R17
                default: ;
            endcase
        end
    end

    always_comb begin
        case (idx)
            IDX_GAP1: rd_mux = gap_r[0];
            IDX_GAP2: rd_mux = gap_r[1];
            IDX_SAMP: rd_mux = samp_r;
            IDX_EPC1: rd_mux = epc_r[0];
            IDX_EPC2: rd_mux = epc_r[1];
            IDX_ZEN: rd_mux = zen_r;
            IDX_SZL1: rd_mux = szl_r[0];
            IDX_SZL2: rd_mux = szl_r[1];
            IDX_SZH1: rd_mux = szh_r[0];
            IDX_SZH2: rd_mux = szh_r[1];
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control request handling
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl_state_r <= CS_IDLE;
            ee_req <= '0;
            ctl_done <= 1'b0;
            ctl_stall <= 1'b0;
            ctl_rdata <= 8'h00;
        end else if (ce) begin
            ctl_done <= 1'b0;
            ctl_stall <= 1'b0;
            case (ctl_state_r)
                CS_IDLE: begin
                    if (setup_valid) begin
                        if ((is_wr || is_rd) && app == APP_REG) begin
                            ctl_done <= 1'b1;
                            if (is_rd) begin
                                ctl_rdata <= rd_mux;
                            end
                        end else if ((is_wr || is_rd) && app == APP_EE) begin
                            ee_req <= {1'b1, is_wr, idx, setup.w_value[7:0]}; // R11 R12
                            ctl_state_r <= CS_EE;
                        end else begin
                            ctl_stall <= 1'b1;
                        end
                    end
                end
                CS_EE: begin
                    if (setup_valid) begin
                        ctl_stall <= 1'b1;
                    end
                    if (ee_ack) begin
                        ee_req.valid <= 1'b0;
                        ctl_done <= 1'b1;
                        if (!ee_req.write) begin
                            ctl_rdata <= ee_rdata; // R12
                        end
                        ctl_state_r <= CS_IDLE;
                    end
                end
                default: ctl_state_r <= CS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-port timing and bulk-in policy
    logic [1:0][3:0] div_r;
    logic [1:0][7:0] gap_cnt_r;
    logic [1:0][3:0] phase_r;
    logic [1:0][7:0] poll_r;

    for (genvar i = 0; i < 2; i++) begin : g_port
        logic baud_tick;
        logic [9:0] thr;
        logic [9:0] thr_eff;
        logic [9:0] cnt;
        logic [9:0] len;
        logic poll_hit;

        assign baud_tick = os_tick[i] && div_r[i] == OS_LAST; // R3
        assign tx_hold[i] = gap_cnt_r[i] != 8'h00; // R18
        assign thr = {1'b0, szh_r[i][SZH_MSB_BIT], szl_r[i]}; // R9
        assign thr_eff = (thr == 10'h000) ? PKT_MAX : thr;
        assign cnt = {2'b00, bin_count[i]};
        assign len = (szh_r[i][SZH_EN_BIT] && cnt > thr_eff) ? thr_eff : cnt; // R10
        assign poll_hit = {1'b0, poll_r[i]} + 9'h001 >= {1'b0, epc_r[i]}; // R7

        always_ff @(posedge mclk) begin
            if (reset) begin
                div_r[i] <= 4'h0;
            end else if (ce && os_tick[i]) begin
                div_r[i] <= div_r[i] + 4'h1; // R3
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                gap_cnt_r[i] <= 8'h00;
            end else if (ce) begin
                if (tx_char_done[i]) begin
                    gap_cnt_r[i] <= gap_r[i]; // R1
                end else if (baud_tick && gap_cnt_r[i] != 8'h00) begin
                    gap_cnt_r[i] <= gap_cnt_r[i] - 8'h01; // R1
                end
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                phase_r[i] <= 4'h0;
                rx_sample[i] <= 1'b0;
            end else if (ce) begin
                rx_sample[i] <= os_tick[i] && !rx_bit_start[i]
                    && phase_r[i] == samp_r[i*SAMP_W +: SAMP_W]; // R4 R5
                if (rx_bit_start[i]) begin
                    phase_r[i] <= 4'h0;
                end else if (os_tick[i]) begin
                    phase_r[i] <= phase_r[i] + 4'h1;
                end
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                poll_r[i] <= 8'h00;
                bin_send[i] <= 1'b0;
                bin_zlp[i] <= 1'b0;
                bin_len[i] <= 9'h000;
            end else if (ce) begin
                bin_send[i] <= 1'b0;
                bin_zlp[i] <= 1'b0;
                if (bin_req[i]) begin
                    if (bin_count[i] != 8'h00) begin
                        bin_send[i] <= 1'b1;
                        bin_len[i] <= len[8:0]; // R9
                        poll_r[i] <= 8'h00;
                    end else if (zen_r[i*ZEN_STEP] && poll_hit) begin
                        bin_zlp[i] <= 1'b1; // R6 R8
                        bin_len[i] <= 9'h000;
                        poll_r[i] <= 8'h00;
                    end else if (poll_r[i] != 8'hFF) begin
                        poll_r[i] <= poll_r[i] + 8'h01; // R7
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status endpoint report
    logic st_on_r;
    logic st_ext_r;
    logic [3:0] st_idx_r;
    logic st_in_ready;
    logic st_push;
    ust_st_word_type st_in;
    logic [7:0] fifo_stat;

    assign fifo_stat = {2'b00, bin_count[1] != 8'h00, bout_count[1] == 8'h00,
        2'b00, bin_count[0] != 8'h00, bout_count[0] == 8'h00}; // R16 R17
    assign st_push = st_on_r && st_in_ready;

    always_comb begin
        st_in.last = st_idx_r == (st_ext_r ? ST_LAST_EXT : ST_LAST_BASE); // R13 R14
        case (st_idx_r)
            4'h0: st_in.data = irq_ident[0]; // R13
            4'h2: st_in.data = irq_ident[1]; // R13
            4'h4: st_in.data = fifo_stat; // R13
            4'h5: st_in.data = bin_count[0]; // R15
            4'h6: st_in.data = bout_count[0]; // R15
            4'h9: st_in.data = bin_count[1]; // R15
            4'hA: st_in.data = bout_count[1]; // R15
            default: st_in.data = 8'h00; // R17
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_on_r <= 1'b0;
            st_ext_r <= 1'b0;
            st_idx_r <= 4'h0;
        end else if (ce) begin
            if (!st_on_r && status_poll) begin
                st_on_r <= 1'b1;
                st_idx_r <= 4'h0;
                st_ext_r <= device_config_one[CFG_EXT_BIT]; // R14
            end else if (st_push) begin
                st_idx_r <= st_idx_r + 4'h1;
                if (st_in.last) begin
                    st_on_r <= 1'b0;
                end
            end
        end
    end

    ust_fifo #(.WIDTH($bits(ust_st_word_type)), .DEPTH(ST_FIFO_DEPTH)) u_st_fifo (
        .clk(mclk),
        .reset(reset),
        .ce(ce),
        .in_valid(st_on_r),
        .in_ready(st_in_ready),
        .in_data(st_in),
        .out_valid(st_valid),
        .out_ready(st_ready),
        .out_data(st_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_gap_load;
        @(posedge mclk) disable iff (reset)
        ce && tx_char_done[0] |=> gap_cnt_r[0] == $past(gap_r[0]);
    endproperty
    a_gap_load: assert property (p_gap_load) else $error("gap not loaded"); // R1

    property p_gap_zero;
        @(posedge mclk) disable iff (reset)
        ce && tx_char_done[1] && gap_r[1] == 8'h00 |=> !tx_hold[1];
    endproperty
    a_gap_zero: assert property (p_gap_zero) else $error("idle with zero gap"); // R18

    property p_gap2_wr;
        @(posedge mclk) disable iff (reset)
        reg_wr && idx == IDX_GAP2 |=> gap_r[1] == $past(setup.w_value[7:0]);
    endproperty
    a_gap2_wr: assert property (p_gap2_wr) else $error("gap two not written"); // R2

    property p_samp1;
        @(posedge mclk) disable iff (reset)
        rx_sample[0] |-> $past(phase_r[0]) == $past(samp_r[3:0]);
    endproperty
    a_samp1: assert property (p_samp1) else $error("port one sample tick"); // R4

    property p_samp2;
        @(posedge mclk) disable iff (reset)
        rx_sample[1] |-> $past(phase_r[1]) == $past(samp_r[7:4]);
    endproperty
    a_samp2: assert property (p_samp2) else $error("port two sample tick"); // R5

    property p_zlp_empty;
        @(posedge mclk) disable iff (reset)
        bin_zlp[0] |-> $past(bin_count[0]) == 8'h00 && $past(zen_r[0]);
    endproperty
    a_zlp_empty: assert property (p_zlp_empty) else $error("bad empty packet"); // R6

    property p_thr_off;
        @(posedge mclk) disable iff (reset)
        bin_send[0] && !$past(szh_r[0][SZH_EN_BIT]) |-> bin_len[0] == {1'b0, $past(bin_count[0])};
    endproperty
    a_thr_off: assert property (p_thr_off) else $error("threshold used"); // R10

    property p_ee_wr;
        @(posedge mclk) disable iff (reset)
        ce && ctl_state_r == CS_IDLE && setup_valid && is_wr && app == APP_EE
        |=> ee_req.valid && ee_req.write && ee_req.data == $past(setup.w_value[7:0]);
    endproperty
    a_ee_wr: assert property (p_ee_wr) else $error("eeprom write lost"); // R11

    property p_st_short;
        @(posedge mclk) disable iff (reset)
        st_push && st_in.last && !st_ext_r |-> st_idx_r == ST_LAST_BASE;
    endproperty
    a_st_short: assert property (p_st_short) else $error("short report length"); // R13

    property p_st_long;
        @(posedge mclk) disable iff (reset)
        st_push && st_in.last && st_ext_r |-> st_idx_r == ST_LAST_EXT;
    endproperty
    a_st_long: assert property (p_st_long) else $error("long report length"); // R14

    c_zlp: cover property (@(posedge mclk) disable iff (reset) bin_zlp[0]);
    c_ee_rd: cover property (@(posedge mclk) disable iff (reset)
        ctl_state_r == CS_EE && ee_ack && !ee_req.write);
    c_st_full: cover property (@(posedge mclk) disable iff (reset) st_valid && !st_ready
        && !st_in_ready);
endmodule
